/* status_pkg.sv */
package status_pkg;

  // standard event status bit positions
  localparam int EV_OPC = 0;
  localparam int EV_RQC = 1;
  localparam int EV_QYE = 2;
  localparam int EV_DDE = 3;
  localparam int EV_EXE = 4;
  localparam int EV_CME = 5;
  localparam int EV_URQ = 6;
  localparam int EV_PON = 7;

  // pulse/ramp conflict bit positions
  localparam int PR_WID_PER  = 0;
  localparam int PR_GAP      = 1;
  localparam int PR_RISE     = 2;
  localparam int PR_FALL     = 3;
  localparam int PR_BURST    = 4;
  localparam int PR_RAMP     = 5;
  localparam int PR_WID_MIN  = 6;
  localparam int PR_WID_MAX  = 7;

  // reset values
  localparam logic [7:0]  EVENT_MASK_RST = 8'h00;
  localparam logic [15:0] CAL16_RST      = 16'h0000;
  localparam logic [7:0]  CAL8_RST       = 8'h00;

  // cal register A: frequency bits 8:0, amplitude bits 13:9
  localparam int CAL_A_FREQ_BITS = 9;
  localparam int CAL_A_AMP_BITS  = 5;
  localparam logic [15:0] CAL_A_USED = 16'h3fff;

  // time figures in picoseconds, fixed-point ratios in 1/100
  localparam logic [47:0] MIN_GAP_PS    = 48'd10000;
  localparam logic [47:0] MIN_WIDTH_PS  = 48'd10000;
  localparam logic [47:0] MAX_WIDTH_PS  = 48'd999000000000;
  localparam logic [47:0] MAX_RAMP_PS   = 48'd5000000;
  localparam logic [7:0]  WIDTH_RATIO   = 8'd80;
  localparam logic [7:0]  EDGE_RATIO    = 8'd125;
  localparam logic [7:0]  RATIO_ONE     = 8'd100;

  // panel indication time in ms and its cycle count at 40 MHz
  localparam int CLK_HZ          = 40000000;
  localparam int INDICATION_MS   = 1000;
  localparam int INDICATION_CYC  = CLK_HZ / 1000 * INDICATION_MS;

  // register select for queries
  typedef enum logic [5:0] {
    SEL_MASK  = 6'b000001,
    SEL_CAL_A = 6'b000010,
    SEL_CAL_B = 6'b000100,
    SEL_CAL_C = 6'b001000,
    SEL_ERR   = 6'b010000,
    SEL_STT   = 6'b100000
  } query_sel_t;

  // pulse parameter set, all times in ps
  typedef struct packed {
    logic [47:0] width;
    logic [47:0] period;
    logic [47:0] trig_period;
    logic [47:0] rise;
    logic [47:0] fall;
    logic [47:0] ramp;
    logic [15:0] burst_count;
    logic        triggered;
    logic        ext_trigger;
    logic        fast_edges;
  } pulse_params_t;

  // command decoder report
  typedef struct packed {
    logic bad_header;
    logic bad_param;
    logic discard;
  } cmd_error_t;

endpackage

/* status_error_reporting.sv */
`timescale 1ns/1ps
`default_nettype none
module status_error_reporting #(
  parameter bit PULSE_VARIANT      = 1'b1,
  parameter int INDICATION_CYCLES  = status_pkg::INDICATION_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rstn_i,
  input  wire logic                      mask_wr_i,
  input  wire logic [7:0]                mask_wdata_i,
  input  wire logic                      query_i,
  input  wire status_pkg::query_sel_t    query_sel_i,
  input  wire logic                      clear_status_i,
  input  wire logic [7:0]                std_event_set_i,
  input  wire logic                      event_read_i,
  input  wire logic [15:0]               cal_a_set_i,
  input  wire logic [7:0]                cal_b_set_i,
  input  wire logic [15:0]               cal_c_set_i,
  input  wire status_pkg::pulse_params_t params_i,
  input  wire logic [39:0]               panel_settings_i,
  input  wire status_pkg::cmd_error_t    cmd_err_i,
  output logic [39:0]                    query_data_o,
  output logic                           query_valid_o,
  output logic [7:0]                     event_status_o,
  output logic                           event_summary_o,
  output logic                           cal_a_summary_o,
  output logic                           cal_b_summary_o,
  output logic                           cal_c_summary_o,
  output logic                           pulse_ramp_summary_o,
  output logic [7:0]                     pulse_ramp_conflicts_o,
  output logic                           discard_unit_o,
  output logic                           bad_header_indication_o,
  output logic                           bad_parameter_indication_o
);

  // standard event enable mask
  logic [7:0]  event_enable_mask;
  logic [7:0]  next_event_enable_mask;

  // standard event register and command error events
  logic [7:0]  event_reg;
  logic [7:0]  next_event_reg;
  logic [7:0]  cmd_events;

  // calibration failure registers
  logic [15:0] cal_fail_freq_amp;
  logic [15:0] next_cal_fail_freq_amp;
  logic [7:0]  cal_fail_offset_pll_burst;
  logic [7:0]  next_cal_fail_offset_pll_burst;
  logic [15:0] cal_fail_width_edges;
  logic [15:0] next_cal_fail_width_edges;

  // pulse/ramp conflict register and live conditions
  logic [7:0]  pulse_ramp_conflicts;
  logic [7:0]  next_pulse_ramp_conflicts;
  logic [7:0]  conflicts;

  // query answer
  logic [39:0] query_data;
  logic [39:0] next_query_data;
  logic        query_valid;
  logic        next_query_valid;

  // panel indication timer and flags
  logic [31:0] ind_count;
  logic [31:0] next_ind_count;
  logic        ind_header;
  logic        next_ind_header;
  logic        ind_param;
  logic        next_ind_param;

  // message unit discard strobe
  logic        discard_unit;
  logic        next_discard_unit;

  // effective period terms and products
  logic [47:0] eff_period;
  logic [47:0] gap;
  logic [55:0] width_x100;
  logic [55:0] period_x80;
  logic [55:0] rise_x125;
  logic [55:0] fall_x125;
  logic [55:0] gap_x100;
  logic [63:0] burst_total;
  logic [15:0] eff_count;
  logic [47:0] eff_trail;

  // pulse/ramp conflict conditions, live from the parameters
  always_comb
  begin
    eff_period = params_i.triggered ? params_i.trig_period : params_i.period;
    gap        = (eff_period > params_i.width) ? eff_period - params_i.width : 48'h0;
    width_x100 = 56'(params_i.width) * 56'(status_pkg::RATIO_ONE);
    period_x80 = 56'(eff_period) * 56'(status_pkg::WIDTH_RATIO);
    rise_x125  = 56'(params_i.rise) * 56'(status_pkg::EDGE_RATIO);
    fall_x125  = 56'(params_i.fall) * 56'(status_pkg::EDGE_RATIO);
    gap_x100   = 56'(gap) * 56'(status_pkg::RATIO_ONE);
    eff_count  = params_i.triggered ? 16'h0001 : params_i.burst_count;
    eff_trail  = params_i.fast_edges ? 48'h0 : params_i.fall;
    burst_total = 64'(eff_count) * 64'(params_i.period) + 64'(eff_trail);
    conflicts = 8'h00;
    conflicts[status_pkg::PR_WID_PER] = width_x100 > period_x80;
    conflicts[status_pkg::PR_GAP] = (eff_period < params_i.width) ||
                                    (gap < status_pkg::MIN_GAP_PS);
    conflicts[status_pkg::PR_RISE] = rise_x125 > width_x100;
    conflicts[status_pkg::PR_FALL] = (eff_period < params_i.width) ||
                                     (fall_x125 > gap_x100);
    conflicts[status_pkg::PR_BURST] = burst_total > 64'(params_i.trig_period);
    conflicts[status_pkg::PR_RAMP] = params_i.ramp > status_pkg::MAX_RAMP_PS;
    conflicts[status_pkg::PR_WID_MIN] = params_i.width < status_pkg::MIN_WIDTH_PS;
    conflicts[status_pkg::PR_WID_MAX] = params_i.width > status_pkg::MAX_WIDTH_PS;
    if (params_i.ext_trigger)
    begin
      conflicts[status_pkg::PR_WID_PER] = 1'b0;
      conflicts[status_pkg::PR_GAP]     = 1'b0;
      conflicts[status_pkg::PR_FALL]    = 1'b0;
    end
    if (!PULSE_VARIANT)
    begin
      conflicts = 8'h00;
    end
  end

  // standard events raised by a rejected command
  always_comb
  begin
    cmd_events = 8'h00;
    cmd_events[status_pkg::EV_CME] = cmd_err_i.bad_header;
    cmd_events[status_pkg::EV_EXE] = cmd_err_i.bad_param;
  end

  // mask load from the controller
  always_comb
  begin
    next_event_enable_mask = event_enable_mask;
    if (mask_wr_i)
    begin
      next_event_enable_mask = mask_wdata_i;
    end
  end

  // mask register, kept until the next load
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      event_enable_mask <= status_pkg::EVENT_MASK_RST;
    end
    else
    begin
      event_enable_mask <= next_event_enable_mask;
    end
  end

  // event register: clear first, then new events, so a set wins over a clear
  always_comb
  begin
    next_event_reg = event_reg;
    if (clear_status_i || event_read_i)
    begin
      next_event_reg = 8'h00;
    end
    next_event_reg = next_event_reg | std_event_set_i | cmd_events;
  end

  // event register storage
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      event_reg <= 8'h00;
    end
    else
    begin
      event_reg <= next_event_reg;
    end
  end

  // cal failures: clear-status and own query clear, new failures win
  always_comb
  begin
    next_cal_fail_freq_amp         = cal_fail_freq_amp;
    next_cal_fail_offset_pll_burst = cal_fail_offset_pll_burst;
    next_cal_fail_width_edges      = cal_fail_width_edges;
    if (clear_status_i)
    begin
      next_cal_fail_freq_amp         = status_pkg::CAL16_RST;
      next_cal_fail_offset_pll_burst = status_pkg::CAL8_RST;
      next_cal_fail_width_edges      = status_pkg::CAL16_RST;
    end
    if (query_i)
    begin
      unique case (query_sel_i)
        status_pkg::SEL_CAL_A: next_cal_fail_freq_amp = status_pkg::CAL16_RST;
        status_pkg::SEL_CAL_B: next_cal_fail_offset_pll_burst = status_pkg::CAL8_RST;
        status_pkg::SEL_CAL_C: next_cal_fail_width_edges = status_pkg::CAL16_RST;
        default: ;
      endcase
    end
    next_cal_fail_freq_amp = next_cal_fail_freq_amp |
                             (cal_a_set_i & status_pkg::CAL_A_USED);
    next_cal_fail_offset_pll_burst = next_cal_fail_offset_pll_burst | cal_b_set_i;
    next_cal_fail_width_edges = next_cal_fail_width_edges | cal_c_set_i;
  end

  // cal failure storage
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cal_fail_freq_amp         <= status_pkg::CAL16_RST;
      cal_fail_offset_pll_burst <= status_pkg::CAL8_RST;
      cal_fail_width_edges      <= status_pkg::CAL16_RST;
    end
    else
    begin
      cal_fail_freq_amp         <= next_cal_fail_freq_amp;
      cal_fail_offset_pll_burst <= next_cal_fail_offset_pll_burst;
      cal_fail_width_edges      <= next_cal_fail_width_edges;
    end
  end

  // conflict register follows the live conditions, reads never touch it
  always_comb
  begin
    next_pulse_ramp_conflicts = conflicts;
  end

  // conflict register storage
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pulse_ramp_conflicts <= 8'h00;
    end
    else
    begin
      pulse_ramp_conflicts <= next_pulse_ramp_conflicts;
    end
  end

  // query answer, snapshot of the selected register
  always_comb
  begin
    next_query_valid = query_i;
    next_query_data  = query_data;
    if (query_i)
    begin
      unique case (query_sel_i)
        status_pkg::SEL_MASK:  next_query_data = {32'h0, event_enable_mask};
        status_pkg::SEL_CAL_A: next_query_data = {24'h0, cal_fail_freq_amp};
        status_pkg::SEL_CAL_B: next_query_data = {32'h0, cal_fail_offset_pll_burst};
        status_pkg::SEL_CAL_C: next_query_data = {24'h0, cal_fail_width_edges};
        status_pkg::SEL_ERR:   next_query_data = {32'h0, pulse_ramp_conflicts};
        status_pkg::SEL_STT:   next_query_data = panel_settings_i;
        default:               next_query_data = 40'h0;
      endcase
    end
  end

  // query answer storage, held until the next query
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      query_data  <= 40'h0;
      query_valid <= 1'b0;
    end
    else
    begin
      query_data  <= next_query_data;
      query_valid <= next_query_valid;
    end
  end

  // any decoder error drops the current message unit
  always_comb
  begin
    next_discard_unit = cmd_err_i.discard | cmd_err_i.bad_header | cmd_err_i.bad_param;
  end

  // discard strobe, one cycle long
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      discard_unit <= 1'b0;
    end
    else
    begin
      discard_unit <= next_discard_unit;
    end
  end

  // panel indication timer, retriggered by each new error
  always_comb
  begin
    next_ind_count  = ind_count;
    next_ind_header = ind_header;
    next_ind_param  = ind_param;
    if (cmd_err_i.bad_header || cmd_err_i.bad_param)
    begin
      next_ind_count  = 32'(INDICATION_CYCLES);
      next_ind_header = cmd_err_i.bad_header;
      next_ind_param  = cmd_err_i.bad_param & ~cmd_err_i.bad_header;
    end
    else if (ind_count != 32'h0)
    begin
      next_ind_count = ind_count - 32'h1;
      if (ind_count == 32'h1)
      begin
        next_ind_header = 1'b0;
        next_ind_param  = 1'b0;
      end
    end
  end

  // indication timer and flags
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ind_count  <= 32'h0;
      ind_header <= 1'b0;
      ind_param  <= 1'b0;
    end
    else
    begin
      ind_count  <= next_ind_count;
      ind_header <= next_ind_header;
      ind_param  <= next_ind_param;
    end
  end

  // summaries toward the status byte
  assign event_summary_o      = |(event_reg & event_enable_mask);
  assign cal_a_summary_o      = |cal_fail_freq_amp;
  assign cal_b_summary_o      = |cal_fail_offset_pll_burst;
  assign cal_c_summary_o      = |cal_fail_width_edges;
  assign pulse_ramp_summary_o = |pulse_ramp_conflicts;

  // register contents straight to the pins
  assign pulse_ramp_conflicts_o     = pulse_ramp_conflicts;
  assign event_status_o             = event_reg;
  assign query_data_o               = query_data;
  assign query_valid_o              = query_valid;
  assign discard_unit_o             = discard_unit;
  assign bad_header_indication_o    = ind_header;
  assign bad_parameter_indication_o = ind_param;

endmodule
`default_nettype wire

/* status_checker_props.sv */
`timescale 1ns/1ps
`default_nettype none
module status_checker (
  input wire logic                      clk_i,
  input wire logic                      rstn_i,
  input wire logic                      query_i,
  input wire status_pkg::query_sel_t    query_sel_i,
  input wire logic [15:0]               cal_a_set_i,
  input wire logic [7:0]                cal_b_set_i,
  input wire status_pkg::pulse_params_t params_i,
  input wire status_pkg::cmd_error_t    cmd_err_i,
  input wire logic                      query_valid_o,
  input wire logic [7:0]                event_status_o,
  input wire logic                      event_summary_o,
  input wire logic                      cal_a_summary_o,
  input wire logic                      cal_b_summary_o,
  input wire logic                      pulse_ramp_summary_o,
  input wire logic [7:0]                pulse_ramp_conflicts_o,
  input wire logic                      discard_unit_o,
  input wire logic                      bad_header_indication_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  chk_summary_pending: assert property (event_summary_o |-> event_status_o != 8'h00)
    else $error("event summary high with no pending event");
  chk_cal_clear: assert property (query_i && query_sel_i == status_pkg::SEL_CAL_A
    && cal_a_set_i == 16'h0000 |=> !cal_a_summary_o)
    else $error("cal A summary survived its query");
  chk_cal_forward: assert property (cal_b_set_i != 8'h00 |=> cal_b_summary_o)
    else $error("cal B failure not forwarded");
  chk_query_answer: assert property (query_valid_o == $past(query_i))
    else $error("query answer not one cycle after request");
  chk_ext_quiet: assert property ($past(rstn_i, 2) && $past(params_i.ext_trigger)
    |-> (pulse_ramp_conflicts_o & 8'h0b) == 8'h00)
    else $error("conflict bit set under external trigger");
  chk_pr_summary: assert property (pulse_ramp_summary_o == |pulse_ramp_conflicts_o)
    else $error("conflict summary disagrees with register");
  chk_width_min: assert property ($past(rstn_i, 2)
    && $past(params_i.width) < status_pkg::MIN_WIDTH_PS |-> pulse_ramp_conflicts_o[6])
    else $error("narrow width not flagged");
  chk_header_hold: assert property (cmd_err_i.bad_header |=> bad_header_indication_o [*8])
    else $error("header indication too short");
  chk_header_event: assert property (cmd_err_i.bad_header |=> event_status_o[5])
    else $error("bad header did not set command error");
  chk_discard_unit: assert property (cmd_err_i.discard |=> discard_unit_o)
    else $error("discard not reported");
endmodule
`default_nettype wire

/* bus_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
  input  wire logic                   clk_i,
  input  wire logic [39:0]            query_data_i,
  output logic                        mask_wr_o,
  output logic [7:0]                  mask_wdata_o,
  output logic                        query_o,
  output status_pkg::query_sel_t      query_sel_o,
  output logic                        clear_status_o,
  output status_pkg::cmd_error_t      cmd_err_o
);
  // idle bus at time zero
  initial
  begin
    mask_wr_o = 1'b0;
    mask_wdata_o = 8'h00;
    query_o = 1'b0;
    query_sel_o = status_pkg::SEL_MASK;
    clear_status_o = 1'b0;
    cmd_err_o = '0;
  end
  // mask load with an 8-bit value
  task automatic write_mask(input logic [7:0] w);
    @(posedge clk_i);
    mask_wr_o <= 1'b1;
    mask_wdata_o <= w;
    @(posedge clk_i);
    mask_wr_o <= 1'b0;
  endtask
  // query, answer taken one cycle after the request edge
  task automatic read_reg(input status_pkg::query_sel_t s, output logic [39:0] d);
    @(posedge clk_i);
    query_o <= 1'b1;
    query_sel_o <= s;
    @(posedge clk_i);
    query_o <= 1'b0;
    #1 d = query_data_i;
  endtask
  // clear-status command or a decoder error report
  task automatic command(input logic clr, input status_pkg::cmd_error_t e);
    @(posedge clk_i);
    clear_status_o <= clr;
    cmd_err_o <= e;
    @(posedge clk_i);
    clear_status_o <= 1'b0;
    cmd_err_o <= '0;
    #1;
  endtask
endmodule
`default_nettype wire

/* status_error_reporting_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module status_error_reporting_tb;
  logic clk_i, rstn_i, mask_wr_i, query_i, clear_status_i, event_read_i, query_valid_o;
  logic event_summary_o, cal_a_summary_o, cal_b_summary_o, cal_c_summary_o;
  logic pulse_ramp_summary_o, discard_unit_o, bad_header_indication_o;
  logic bad_parameter_indication_o;
  logic [7:0]                mask_wdata_i, std_event_set_i, cal_b_set_i, event_status_o, w;
  logic [7:0]                pulse_ramp_conflicts_o;
  logic [15:0]               cal_a_set_i, cal_c_set_i;
  logic [39:0]               panel_settings_i, query_data_o, rd;
  status_pkg::query_sel_t    query_sel_i;
  status_pkg::pulse_params_t params_i;
  status_pkg::pulse_params_t cases [11];
  status_pkg::cmd_error_t    cmd_err_i;
  logic [7:0]                expv [11] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h08, 8'h10, 8'h20,
                                           8'h40, 8'h8b, 8'h00, 8'h00};
  int                        err_count = 0;
  int                        cmp_count = 0;
  status_error_reporting #(.INDICATION_CYCLES(20)) dut (.clk_i, .rstn_i, .mask_wr_i,
    .mask_wdata_i, .query_i, .query_sel_i, .clear_status_i, .std_event_set_i, .event_read_i,
    .cal_a_set_i, .cal_b_set_i, .cal_c_set_i, .params_i, .panel_settings_i, .cmd_err_i,
    .query_data_o, .query_valid_o, .event_status_o, .event_summary_o, .cal_a_summary_o,
    .cal_b_summary_o, .cal_c_summary_o, .pulse_ramp_summary_o, .pulse_ramp_conflicts_o,
    .discard_unit_o, .bad_header_indication_o, .bad_parameter_indication_o);
  bus_ctrl_model ctrl (.clk_i(clk_i), .query_data_i(query_data_o), .mask_wr_o(mask_wr_i),
    .mask_wdata_o(mask_wdata_i), .query_o(query_i), .query_sel_o(query_sel_i),
    .clear_status_o(clear_status_i), .cmd_err_o(cmd_err_i));
  // 40 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic check(input string n, input logic [39:0] s, input logic [39:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one-cycle pulses on event and cal failure inputs
  task automatic pulse(input logic [7:0] ev, input logic r, input logic [15:0] a,
                       input logic [7:0] b, input logic [15:0] c);
    @(posedge clk_i);
    std_event_set_i <= ev;
    event_read_i <= r;
    cal_a_set_i <= a;
    cal_b_set_i <= b;
    cal_c_set_i <= c;
    @(posedge clk_i);
    {std_event_set_i, event_read_i, cal_a_set_i, cal_b_set_i, cal_c_set_i} <= '0;
    #1;
  endtask
  // period 1 us, trigger period 10 us, fast edges
  function automatic status_pkg::pulse_params_t pp(input logic [47:0] wd, r, f, rp,
                                                   input logic [15:0] n, input logic t, x);
    pp = '{wd, 48'hf4240, 48'h989680, r, f, rp, n, t, x, 1'b1};
  endfunction
  // hang guard
  initial
  begin
    #100000;
    err_count++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    {std_event_set_i, event_read_i, cal_a_set_i, cal_b_set_i, cal_c_set_i} = '0;
    panel_settings_i = 40'h123456789a;
    cases[0] = pp(48'h186a0, 48'h3e8, 48'h3e8, 48'h0, 16'h1, 1'b0, 1'b0);
    cases[1] = pp(48'hdbba0, 48'h3e8, 48'h3e8, 48'h0, 16'h1, 1'b0, 1'b0);
    cases[2] = pp(48'hf2eb8, 48'h3e8, 48'h3e8, 48'h0, 16'h1, 1'b0, 1'b0);
    cases[3] = pp(48'h186a0, 48'h186a0, 48'h3e8, 48'h0, 16'h1, 1'b0, 1'b0);
    cases[4] = pp(48'h7a120, 48'h3e8, 48'h7a120, 48'h0, 16'h1, 1'b0, 1'b0);
    cases[5] = pp(48'h186a0, 48'h3e8, 48'h3e8, 48'h0, 16'h14, 1'b0, 1'b0);
    cases[6] = pp(48'h186a0, 48'h3e8, 48'h3e8, 48'h5b8d80, 16'h1, 1'b0, 1'b0);
    cases[7] = pp(48'h1388, 48'h3e8, 48'h3e8, 48'h0, 16'h1, 1'b0, 1'b0);
    cases[8] = pp(48'he8d4a51000, 48'h3e8, 48'h3e8, 48'h0, 16'h1, 1'b0, 1'b0);
    cases[9] = pp(48'hf2eb8, 48'h3e8, 48'h7a120, 48'h0, 16'h1, 1'b0, 1'b1);
    cases[10] = pp(48'hdbba0, 48'h3e8, 48'h3e8, 48'h0, 16'h14, 1'b1, 1'b0);
    params_i = cases[0];
    rstn_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    // each weight alone: readback, gating, clear on event read
    for (int i = 0; i < 8; i++)
    begin
      w = 8'h01 << i;
      ctrl.write_mask(w);
      ctrl.read_reg(status_pkg::SEL_MASK, rd);
      check("mask", rd, {32'h0, w});
      pulse(~w, 1'b0, 16'h0, 8'h00, 16'h0);
      check("summary_blocked", event_summary_o, 40'h0);
      pulse(w, 1'b0, 16'h0, 8'h00, 16'h0);
      check("summary_on", event_summary_o, 40'h1);
      pulse(8'h00, 1'b1, 16'h0, 8'h00, 16'h0);
      check("summary_read", event_summary_o, 40'h0);
    end
    ctrl.write_mask(8'h00);
    ctrl.read_reg(status_pkg::SEL_MASK, rd);
    check("mask_zero", rd, 40'h0);
    // cal failure registers
    pulse(8'h00, 1'b0, 16'hffff, 8'ha5, 16'hffff);
    check("cal_sums", {cal_a_summary_o, cal_b_summary_o, cal_c_summary_o}, 40'h7);
    ctrl.read_reg(status_pkg::SEL_CAL_A, rd);
    check("cal_a", rd, 40'h3fff);
    ctrl.read_reg(status_pkg::SEL_CAL_A, rd);
    check("cal_a_cleared", rd, 40'h0);
    ctrl.read_reg(status_pkg::SEL_CAL_C, rd);
    check("cal_c", rd, 40'hffff);
    ctrl.read_reg(status_pkg::SEL_CAL_B, rd);
    check("cal_b", rd, 40'ha5);
    pulse(8'hff, 1'b0, 16'h0, 8'h5a, 16'h0);
    ctrl.command(1'b1, '0);
    check("events_cls", event_status_o, 40'h0);
    ctrl.read_reg(status_pkg::SEL_CAL_B, rd);
    check("cal_b_cls", rd, 40'h0);
    // conflict table, read twice each time
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk_i);
      params_i <= cases[i];
      repeat (2) @(posedge clk_i);
      #1 check("conflicts", pulse_ramp_conflicts_o, expv[i]);
      check("pr_summary", pulse_ramp_summary_o, |expv[i]);
      repeat (2)
      begin
        ctrl.read_reg(status_pkg::SEL_ERR, rd);
        check("err_query", rd, expv[i]);
      end
    end
    // panel snapshot, non-destructive
    repeat (2)
    begin
      ctrl.read_reg(status_pkg::SEL_STT, rd);
      check("snapshot", rd, 40'h123456789a);
    end
    // invalid header, then invalid parameter
    ctrl.command(1'b0, '{1'b1, 1'b0, 1'b1});
    check("hdr", {event_status_o[5], discard_unit_o, bad_header_indication_o}, 40'h7);
    repeat (25) @(posedge clk_i);
    #1 check("hdr_off", bad_header_indication_o, 40'h0);
    ctrl.command(1'b0, '{1'b0, 1'b1, 1'b1});
    check("par", {event_status_o[4], bad_parameter_indication_o}, 40'h3);
    end_of_test();
  end
endmodule
bind status_error_reporting status_checker chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .query_i(query_i), .query_sel_i(query_sel_i), .cal_a_set_i(cal_a_set_i),
  .cal_b_set_i(cal_b_set_i), .params_i(params_i), .cmd_err_i(cmd_err_i),
  .query_valid_o(query_valid_o), .event_status_o(event_status_o),
  .event_summary_o(event_summary_o), .cal_a_summary_o(cal_a_summary_o),
  .cal_b_summary_o(cal_b_summary_o), .pulse_ramp_summary_o(pulse_ramp_summary_o),
  .pulse_ramp_conflicts_o(pulse_ramp_conflicts_o), .discard_unit_o(discard_unit_o),
  .bad_header_indication_o(bad_header_indication_o));
`default_nettype wire
